// ===== rtl/txcf_map.svh
`ifndef TXCF_MAP_SVH
`define TXCF_MAP_SVH
// Summary of operation
// R01: force bit clear lets aux output follow aux input, set forces active.
// R02: invert bit flips the active level of the aux output.
// R03: tx2 alarm hold bit keeps adc alarm flags set, else they track.
// R04: tx2 fast-trip hold bit keeps fast-trip flags set, else they track.
// R05: tx2 warning hold bit keeps adc warning flags set, else they track.
// R06: tx1 alarm hold bit keeps adc alarm flags set, else they track.
// R07: tx1 fast-trip hold bit keeps fast-trip flags set, else they track.
// R08: tx1 warning hold bit keeps adc warning flags set, else they track.
// R09: both config bytes reset to zero and serve both transmitters at once.
// R10: config writes need factory level, or user level with rw permission.
// R11: config reads need factory level, or user level with rw or ro rights.
// R12: fault-gate enable ors the internal fault gate into laser disable.
// R13: fault-pin enable ors the transmit-fault pin into laser disable.
// R14: ignore bit clear ors the transmit-disable input into laser disable.
// R15: with high extension off a high fast-trip alarm raises the fault gate.
// R16: reserved bits 1:0 of the disable byte are stored but do nothing.
// R17: a held flag drops only on a software clear, a reset, or when its hold bit is cleared.

// ==========================================
// register map
`define TXCF_ADDR_OUT_FLAG 8'h89
`define TXCF_ADDR_DIS_SRC 8'h8a
`define TXCF_ADDR_IRQ_STAT 8'hf0
`define TXCF_ADDR_IRQ_MASK 8'hf1
`define TXCF_RST_OUT_FLAG 8'h00
`define TXCF_RST_DIS_SRC 8'h00
`define TXCF_RST_IRQ 4'h0
`define TXCF_RST_PINS 5'h00

// ==========================================
// output and flag latch byte fields
`define TXCF_B_FORCE 7
`define TXCF_B_INV 6
`define TXCF_B_AHOLD2 5
`define TXCF_B_FHOLD2 4
`define TXCF_B_WHOLD2 3
`define TXCF_B_AHOLD1 2
`define TXCF_B_FHOLD1 1
`define TXCF_B_WHOLD1 0

// ==========================================
// disable source byte fields
`define TXCF_C_GATE2 7
`define TXCF_C_FPIN2 6
`define TXCF_C_IGN2 5
`define TXCF_C_GATE1 4
`define TXCF_C_FPIN1 3
`define TXCF_C_IGN1 2

// ==========================================
// interrupt events, pin order and widths
`define TXCF_IRQ_W 4
`define TXCF_EV_DIS1 0
`define TXCF_EV_DIS2 1
`define TXCF_EV_WDENY 2
`define TXCF_EV_RDENY 3
`define TXCF_PIN_N 5
`define TXCF_PIN_FLT1 0
`define TXCF_PIN_FLT2 1
`define TXCF_PIN_DIS1 2
`define TXCF_PIN_DIS2 3
`define TXCF_PIN_AUX 4
`define TXCF_ALARM_W 16
`define TXCF_FT_W 24
`define TXCF_WARN_W 16
`endif

// ===== rtl/txcf_pkg.sv
package txcf_pkg;
    // per-transmitter flag hold selection
    typedef struct packed {
        logic adc_alarm;
        logic fast_trip;
        logic adc_warn;
    } txcf_hold_t;
    // per-transmitter disable source selection
    typedef struct packed {
        logic gate_en;
        logic pin_en;
        logic in_ignore;
    } txcf_dis_cfg_t;
endpackage

// ===== rtl/txcf_flag_hold.sv
`timescale 1ns/1ns
`default_nettype none
module txcf_flag_hold #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // comparison results and control
    input wire logic [W-1:0] cmp,
    input wire logic hold,
    input wire logic [W-1:0] clr,
    // flags
    output logic [W-1:0] flags
);
    // a new comparison beats a software clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            flags <= '0;
        end
        else if (hold)
        begin
            flags <= (flags & ~clr) | cmp;
        end
        else
        begin
            flags <= cmp;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/txcf_disable_or.sv
`timescale 1ns/1ns
`default_nettype none
module txcf_disable_or (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // selection and sources
    input wire txcf_pkg::txcf_dis_cfg_t cfg,
    input wire logic fault_gate,
    input wire logic fault_pin,
    input wire logic disable_in,
    // laser disable
    output logic disable_out
);
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            disable_out <= 1'b0;
        end
        else
        begin
            disable_out <= (cfg.gate_en & fault_gate)
                | (cfg.pin_en & fault_pin)
                | (~cfg.in_ignore & disable_in);
        end
    end
endmodule
`default_nettype wire

// ===== rtl/txcf_top.sv
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "txcf_map.svh"
module txcf_top (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // password state
    input wire logic factory_password_level,
    input wire logic user_password_level,
    input wire logic table2_rw_permission,
    input wire logic table2_read_permission,
    // pins
    input wire logic aux_input_pin,
    input wire logic transmit_fault_pin_tx1,
    input wire logic transmit_fault_pin_tx2,
    input wire logic transmit_disable_in_tx1,
    input wire logic transmit_disable_in_tx2,
    output logic aux_output_pin,
    output logic laser_disable_out_tx1,
    output logic laser_disable_out_tx2,
    // fast-trip fault gate sources
    input wire logic qt_high_alarm_tx1,
    input wire logic qt_high_alarm_tx2,
    input wire logic high_ext_enable_tx1,
    input wire logic high_ext_enable_tx2,
    input wire logic extended_fault_gate_tx1,
    input wire logic extended_fault_gate_tx2,
    // flag comparisons, clears and flags, index 0 is tx1
    input wire logic [1:0][`TXCF_ALARM_W-1:0] adc_alarm_cmp,
    input wire logic [1:0][`TXCF_ALARM_W-1:0] adc_alarm_clr,
    output logic [1:0][`TXCF_ALARM_W-1:0] adc_alarm_flags,
    input wire logic [1:0][`TXCF_FT_W-1:0] fast_trip_cmp,
    input wire logic [1:0][`TXCF_FT_W-1:0] fast_trip_clr,
    output logic [1:0][`TXCF_FT_W-1:0] fast_trip_flags,
    input wire logic [1:0][`TXCF_WARN_W-1:0] adc_warn_cmp,
    input wire logic [1:0][`TXCF_WARN_W-1:0] adc_warn_clr,
    output logic [1:0][`TXCF_WARN_W-1:0] adc_warn_flags,
    // interrupt
    output logic irq
);
    // ==========================================
    // declarations
    logic [7:0] cfg_b_reg;
    logic [7:0] cfg_c_reg;
    logic [`TXCF_IRQ_W-1:0] status_reg;
    logic [`TXCF_IRQ_W-1:0] status_next;
    logic [`TXCF_IRQ_W-1:0] mask_reg;
    logic [`TXCF_IRQ_W-1:0] ev;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [`TXCF_PIN_N-1:0] pin_raw;
    logic [`TXCF_PIN_N-1:0] pin_meta;
    logic [`TXCF_PIN_N-1:0] pin_sync;
    logic hit_b;
    logic hit_c;
    logic hit_s;
    logic hit_m;
    logic wr_ok;
    logic rd_ok;
    logic cfg_wr;
    logic cfg_rd;
    logic aux_out_reg;
    logic internal_fault_gate_tx1;
    logic internal_fault_gate_tx2;
    logic [1:0] fgate;
    logic [1:0] fpin;
    logic [1:0] din;
    logic [1:0] dis_q;
    logic [1:0] dis_prev;
    txcf_pkg::txcf_hold_t hold [2];
    txcf_pkg::txcf_dis_cfg_t dis_cfg [2];

    // ==========================================
    // pin synchronisers
    assign pin_raw = {aux_input_pin, transmit_disable_in_tx2,
        transmit_disable_in_tx1, transmit_fault_pin_tx2,
        transmit_fault_pin_tx1};

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_meta <= `TXCF_RST_PINS;
            pin_sync <= `TXCF_RST_PINS;
        end
        else
        begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // ==========================================
    // address decode and access rights
    always_comb
    begin
        hit_b = 1'b0;
        hit_c = 1'b0;
        hit_s = 1'b0;
        hit_m = 1'b0;
        if (reg_addr == `TXCF_ADDR_OUT_FLAG)
        begin
            hit_b = 1'b1;
        end
        else if (reg_addr == `TXCF_ADDR_DIS_SRC)
        begin
            hit_c = 1'b1;
        end
        else if (reg_addr == `TXCF_ADDR_IRQ_STAT)
        begin
            hit_s = 1'b1;
        end
        else if (reg_addr == `TXCF_ADDR_IRQ_MASK)
        begin
            hit_m = 1'b1;
        end
    end

    assign wr_ok = factory_password_level
        | (user_password_level & table2_rw_permission); // [R10]
    assign rd_ok = factory_password_level
        | (user_password_level
        & (table2_rw_permission | table2_read_permission)); // [R11]
    assign cfg_wr = reg_wr & (hit_b | hit_c);
    assign cfg_rd = reg_rd & (hit_b | hit_c);

    // ==========================================
    // configuration bytes
    // one copy serves both transmitter address spaces
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cfg_b_reg <= `TXCF_RST_OUT_FLAG; // [R09]
        end
        else if (reg_wr && hit_b && wr_ok)
        begin
            cfg_b_reg <= reg_wdata; // [R10]
        end
    end

    // reserved low bits are kept only for read back
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cfg_c_reg <= `TXCF_RST_DIS_SRC; // [R09]
        end
        else if (reg_wr && hit_c && wr_ok)
        begin
            cfg_c_reg <= reg_wdata; // [R10] [R16]
        end
    end

    // ==========================================
    // interrupt status and mask
    assign ev[`TXCF_EV_DIS1] = dis_q[0] & ~dis_prev[0];
    assign ev[`TXCF_EV_DIS2] = dis_q[1] & ~dis_prev[1];
    assign ev[`TXCF_EV_WDENY] = cfg_wr & ~wr_ok;
    assign ev[`TXCF_EV_RDENY] = cfg_rd & ~rd_ok;

    // an event in the clearing read cycle survives
    always_comb
    begin
        status_next = status_reg;
        if (reg_rd && hit_s)
        begin
            status_next = `TXCF_RST_IRQ;
        end
        status_next = status_next | ev;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            status_reg <= `TXCF_RST_IRQ;
            dis_prev <= 2'b00;
        end
        else
        begin
            status_reg <= status_next;
            dis_prev <= dis_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mask_reg <= `TXCF_RST_IRQ;
        end
        else if (reg_wr && hit_m)
        begin
            mask_reg <= reg_wdata[`TXCF_IRQ_W-1:0];
        end
    end

    assign irq = |(status_reg & mask_reg);

    // ==========================================
    // read data, valid only in the cycle after the strobe
    always_comb
    begin
        rdata_next = 8'h00;
        if (!reg_rd)
        begin
            rdata_next = 8'h00;
        end
        else if (hit_b && rd_ok)
        begin
            rdata_next = cfg_b_reg; // [R11]
        end
        else if (hit_c && rd_ok)
        begin
            rdata_next = cfg_c_reg; // [R11]
        end
        else if (hit_s)
        begin
            rdata_next = {4'h0, status_reg};
        end
        else if (hit_m)
        begin
            rdata_next = {4'h0, mask_reg};
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdata_reg <= 8'h00;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ==========================================
    // auxiliary output
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            aux_out_reg <= 1'b0;
        end
        else
        begin
            aux_out_reg <= (cfg_b_reg[`TXCF_B_FORCE]
                | pin_sync[`TXCF_PIN_AUX]) // [R01]
                ^ cfg_b_reg[`TXCF_B_INV]; // [R02]
        end
    end

    assign aux_output_pin = aux_out_reg;

    // ==========================================
    // fault gates, disable sources and flag holds
    // the extension timer lives outside and hands its own gate in
    assign internal_fault_gate_tx1 = extended_fault_gate_tx1
        | (~high_ext_enable_tx1 & qt_high_alarm_tx1); // [R15]
    assign internal_fault_gate_tx2 = extended_fault_gate_tx2
        | (~high_ext_enable_tx2 & qt_high_alarm_tx2); // [R15]
    assign fgate = {internal_fault_gate_tx2, internal_fault_gate_tx1};
    assign fpin = {pin_sync[`TXCF_PIN_FLT2], pin_sync[`TXCF_PIN_FLT1]};
    assign din = {pin_sync[`TXCF_PIN_DIS2], pin_sync[`TXCF_PIN_DIS1]};

    assign hold[0] = {cfg_b_reg[`TXCF_B_AHOLD1],
        cfg_b_reg[`TXCF_B_FHOLD1], cfg_b_reg[`TXCF_B_WHOLD1]};
    assign hold[1] = {cfg_b_reg[`TXCF_B_AHOLD2],
        cfg_b_reg[`TXCF_B_FHOLD2], cfg_b_reg[`TXCF_B_WHOLD2]};
    assign dis_cfg[0] = {cfg_c_reg[`TXCF_C_GATE1],
        cfg_c_reg[`TXCF_C_FPIN1], cfg_c_reg[`TXCF_C_IGN1]};
    assign dis_cfg[1] = {cfg_c_reg[`TXCF_C_GATE2],
        cfg_c_reg[`TXCF_C_FPIN2], cfg_c_reg[`TXCF_C_IGN2]};

    for (genvar t = 0; t < 2; t++)
    begin : g_tx
        // [R12] [R13] [R14]
        txcf_disable_or u_dis (
            .clk(clk),
            .srst(srst),
            .cfg(dis_cfg[t]),
            .fault_gate(fgate[t]),
            .fault_pin(fpin[t]),
            .disable_in(din[t]),
            .disable_out(dis_q[t])
        );
        // [R03] [R06] [R17]
        txcf_flag_hold #(.W(`TXCF_ALARM_W)) u_alarm (
            .clk(clk),
            .srst(srst),
            .cmp(adc_alarm_cmp[t]),
            .hold(hold[t].adc_alarm),
            .clr(adc_alarm_clr[t]),
            .flags(adc_alarm_flags[t])
        );
        // [R04] [R07] [R17]
        txcf_flag_hold #(.W(`TXCF_FT_W)) u_ftrip (
            .clk(clk),
            .srst(srst),
            .cmp(fast_trip_cmp[t]),
            .hold(hold[t].fast_trip),
            .clr(fast_trip_clr[t]),
            .flags(fast_trip_flags[t])
        );
        // [R05] [R08] [R17]
        txcf_flag_hold #(.W(`TXCF_WARN_W)) u_warn (
            .clk(clk),
            .srst(srst),
            .cmp(adc_warn_cmp[t]),
            .hold(hold[t].adc_warn),
            .clr(adc_warn_clr[t]),
            .flags(adc_warn_flags[t])
        );
    end

    assign laser_disable_out_tx1 = dis_q[0];
    assign laser_disable_out_tx2 = dis_q[1];

    // ==========================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_aux_force;
        cfg_b_reg[7] && !cfg_b_reg[6] |=> aux_output_pin;
    endproperty
    a_aux_force: assert property (p_aux_force) // [R01]
        else $error("forced aux output not active");

    property p_aux_follow;
        !cfg_b_reg[7] && !cfg_b_reg[6] && $stable(cfg_b_reg)
            && aux_input_pin ##1 aux_input_pin && $stable(cfg_b_reg)
            ##1 aux_input_pin && $stable(cfg_b_reg)
            |=> aux_output_pin;
    endproperty
    a_aux_follow: assert property (p_aux_follow) // [R01]
        else $error("aux output does not follow input");

    property p_aux_inv;
        cfg_b_reg[7] && cfg_b_reg[6] |=> !aux_output_pin;
    endproperty
    a_aux_inv: assert property (p_aux_inv) // [R02]
        else $error("inverted forced aux output not low");

    property p_alarm2_hold;
        cfg_b_reg[5] && adc_alarm_flags[1][0] && !adc_alarm_clr[1][0]
            |=> adc_alarm_flags[1][0];
    endproperty
    a_alarm2_hold: assert property (p_alarm2_hold) // [R03]
        else $error("held tx2 alarm flag dropped");

    property p_ftrip2_track;
        !cfg_b_reg[4] |=> fast_trip_flags[1] == $past(fast_trip_cmp[1]);
    endproperty
    a_ftrip2_track: assert property (p_ftrip2_track) // [R04]
        else $error("tx2 fast-trip flags do not track");

    property p_warn2_hold;
        cfg_b_reg[3] && adc_warn_flags[1][0] && !adc_warn_clr[1][0]
            |=> adc_warn_flags[1][0];
    endproperty
    a_warn2_hold: assert property (p_warn2_hold) // [R05]
        else $error("held tx2 warning flag dropped");

    property p_alarm1_track;
        !cfg_b_reg[2] |=> adc_alarm_flags[0] == $past(adc_alarm_cmp[0]);
    endproperty
    a_alarm1_track: assert property (p_alarm1_track) // [R06]
        else $error("tx1 alarm flags do not track");

    property p_ftrip1_hold;
        cfg_b_reg[1] && fast_trip_flags[0][0] && !fast_trip_clr[0][0]
            |=> fast_trip_flags[0][0];
    endproperty
    a_ftrip1_hold: assert property (p_ftrip1_hold) // [R07]
        else $error("held tx1 fast-trip flag dropped");

    property p_warn1_track;
        !cfg_b_reg[0] |=> adc_warn_flags[0] == $past(adc_warn_cmp[0]);
    endproperty
    a_warn1_track: assert property (p_warn1_track) // [R08]
        else $error("tx1 warning flags do not track");

    property p_wr_then_rd;
        reg_wr && (hit_b || hit_c) && wr_ok ##1 !reg_wr
            ##1 reg_rd && reg_addr == $past(reg_addr, 2) && rd_ok
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_wr_then_rd: assert property (p_wr_then_rd) // [R09]
        else $error("config byte read back differs");

    property p_wr_denied;
        cfg_wr && !wr_ok |=> $stable(cfg_b_reg) && $stable(cfg_c_reg);
    endproperty
    a_wr_denied: assert property (p_wr_denied) // [R10]
        else $error("config byte changed without rights");

    property p_wr_taken;
        reg_wr && hit_c && wr_ok |=> cfg_c_reg == $past(reg_wdata);
    endproperty
    a_wr_taken: assert property (p_wr_taken) // [R10]
        else $error("permitted write not stored");

    property p_rd_denied;
        cfg_rd && !rd_ok |=> reg_rdata == 8'h00;
    endproperty
    a_rd_denied: assert property (p_rd_denied) // [R11]
        else $error("config byte read without rights");

    property p_gate1;
        cfg_c_reg[4] && internal_fault_gate_tx1 |=> laser_disable_out_tx1;
    endproperty
    a_gate1: assert property (p_gate1) // [R12]
        else $error("fault gate did not disable tx1");

    property p_fpin2;
        cfg_c_reg[6] && pin_sync[1] |=> laser_disable_out_tx2;
    endproperty
    a_fpin2: assert property (p_fpin2) // [R13]
        else $error("fault pin did not disable tx2");

    property p_din1;
        !cfg_c_reg[2] && transmit_disable_in_tx1 ##1
            !cfg_c_reg[2] && transmit_disable_in_tx1 ##1
            !cfg_c_reg[2] |=> laser_disable_out_tx1;
    endproperty
    a_din1: assert property (p_din1) // [R14]
        else $error("disable input did not disable tx1");

    property p_qt_gate2;
        !high_ext_enable_tx2 && qt_high_alarm_tx2 && cfg_c_reg[7]
            |=> laser_disable_out_tx2;
    endproperty
    a_qt_gate2: assert property (p_qt_gate2) // [R15]
        else $error("fast-trip alarm did not gate tx2");

    property p_reserved;
        cfg_c_reg[7:5] == 3'b001 |=> !laser_disable_out_tx2;
    endproperty
    a_reserved: assert property (p_reserved) // [R16]
        else $error("tx2 disabled with all sources off");

    property p_hold_keep;
        cfg_b_reg[2] && adc_alarm_flags[0][0] && !adc_alarm_clr[0][0]
            ##1 cfg_b_reg[2] && !adc_alarm_clr[0][0]
            |=> adc_alarm_flags[0][0];
    endproperty
    a_hold_keep: assert property (p_hold_keep) // [R17]
        else $error("held flag released without a clear");

    property p_irq_deny;
        cfg_wr && !wr_ok && mask_reg[2] |=> irq;
    endproperty
    a_irq_deny: assert property (p_irq_deny)
        else $error("denied write raised no interrupt");

    c_cfg_write: cover property (reg_wr && hit_b && wr_ok);
    c_flag_held: cover property (cfg_b_reg[5] && adc_alarm_flags[1][0]
        && !adc_alarm_cmp[1][0]);
    c_disable: cover property (laser_disable_out_tx1
        && laser_disable_out_tx2);
    c_irq: cover property (irq ##1 reg_rd && hit_s);
endmodule
`default_nettype wire

// ===== dv/txcf_host.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// host software on the register port
module txcf_host (
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // bus is scrambled after the strobe so stale values prove nothing
    task automatic access(input logic w, input logic [7:0] ad,
        input logic [7:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~ad;
        reg_wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] ra, wd, rdat, a, c, v;
    logic rw, rr, aux_o, ld1, ld2, irq, okw, okr, g1, g2;
    // factory, user, table rw, table ro
    logic [3:0] pw = 4'h0;
    // flt1 flt2 dis1 dis2 aux qt1 qt2 hext1 hext2 egate1 egate2
    logic [10:0] src = 11'h000;
    logic [10:0] s;
    logic [1:0][15:0] acmp = '0, aclr = '0, wcmp = '0, wclr = '0, af, wf;
    logic [1:0][23:0] fcmp = '0, fclr = '0, ff;
    logic [31:0] ac, wc;
    logic [47:0] fc;
    logic [7:0] cur [2];
    logic [8:0] expq [$];
    logic [8:0] e;
    logic rd_seen = 1'b0;
    int miscompares = 0;
    int n_compared = 0;
    int j;

    always #50 clk = ~clk;

    txcf_host u_txcf_host (.clk(clk), .reg_addr(ra), .reg_wdata(wd),
        .reg_wr(rw), .reg_rd(rr));

    txcf_top u_txcf_top (.clk(clk), .srst(srst), .reg_addr(ra),
        .reg_wdata(wd), .reg_wr(rw), .reg_rd(rr), .reg_rdata(rdat),
        .factory_password_level(pw[3]), .user_password_level(pw[2]),
        .table2_rw_permission(pw[1]), .table2_read_permission(pw[0]),
        .transmit_fault_pin_tx1(src[0]), .transmit_fault_pin_tx2(src[1]),
        .transmit_disable_in_tx1(src[2]), .transmit_disable_in_tx2(src[3]),
        .aux_input_pin(src[4]), .qt_high_alarm_tx1(src[5]),
        .qt_high_alarm_tx2(src[6]), .high_ext_enable_tx1(src[7]),
        .high_ext_enable_tx2(src[8]), .extended_fault_gate_tx1(src[9]),
        .extended_fault_gate_tx2(src[10]), .aux_output_pin(aux_o),
        .laser_disable_out_tx1(ld1), .laser_disable_out_tx2(ld2),
        .adc_alarm_cmp(acmp), .adc_alarm_clr(aclr), .adc_alarm_flags(af),
        .fast_trip_cmp(fcmp), .fast_trip_clr(fclr), .fast_trip_flags(ff),
        .adc_warn_cmp(wcmp), .adc_warn_clr(wclr), .adc_warn_flags(wf),
        .irq(irq));

    // ==========================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] x,
        input logic [31:0] y);
        n_compared++;
        if (y !== x)
        begin
            $display("ERROR %s expected %h seen %h", nm, x, y);
            miscompares++;
        end
    endtask

    task wr(input logic [7:0] ad, input logic [7:0] d);
        u_txcf_host.access(1'b1, ad, d);
    endtask

    // bit 8 of the note marks a read whose value is not checked
    task rd(input logic [7:0] ad, input logic [8:0] x);
        expq.push_back(x);
        u_txcf_host.access(1'b0, ad, 8'h00);
    endtask

    task end_sim;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================
    // read data monitor
    always @(posedge clk)
    begin
        if (rd_seen)
        begin
            e = expq.pop_front();
            if (!e[8])
                chk("reg_rdata", 32'(e[7:0]), 32'(rdat));
        end
        rd_seen <= rr;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        $display("ERROR timeout expected finish seen no finish");
        miscompares++;
        end_sim();
    end

    // ==========================================
    // tests
    initial
    begin
        void'($urandom(39));
        cur = '{8'h00, 8'h00};
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        pw <= 4'h8;
        rd(8'h89, 9'h000);
        rd(8'h8a, 9'h000);
        rd(8'hf0, 9'h000);
        rd(8'hf1, 9'h000);
        $display("test reset done");
        for (int k = 0; k < 16; k++)
        begin
            v = 8'($urandom());
            j = int'($urandom() % 2);
            a = j ? 8'h8a : 8'h89;
            okw = k[3] | (k[2] & k[1]);
            okr = k[3] | (k[2] & (k[1] | k[0]));
            pw <= 4'(k);
            wr(a, v);
            if (okw)
                cur[j] = v;
            rd(a, okr ? {1'b0, cur[j]} : 9'h000);
            pw <= 4'h8;
            rd(a, {1'b0, cur[j]});
            rd(8'hf0, {5'h00, !okr, !okw, 2'h0});
        end
        wr(8'h55, 8'hff);
        rd(8'h55, 9'h000);
        $display("test access done");
        for (int k = 0; k < 8; k++)
        begin
            wr(8'h89, {k[2:1], 6'h00});
            src[4] <= k[0];
            repeat (5) @(posedge clk);
            chk("aux_output_pin", 32'((k[2] | k[0]) ^ k[1]),
                32'(aux_o));
        end
        $display("test aux done");
        for (int k = 0; k < 16; k++)
        begin
            c = 8'($urandom());
            s = 11'($urandom());
            wr(8'h8a, c);
            src <= s;
            repeat (5) @(posedge clk);
            g1 = s[9] | (~s[7] & s[5]);
            g2 = s[10] | (~s[8] & s[6]);
            chk("disable1", 32'((c[4] & g1) | (c[3] & s[0])
                | (~c[2] & s[2])), 32'(ld1));
            chk("disable2", 32'((c[7] & g2) | (c[6] & s[1])
                | (~c[5] & s[3])), 32'(ld2));
            rd(8'h8a, {1'b0, c});
        end
        $display("test disable done");
        for (int k = 0; k < 6; k++)
        begin
            c = 8'($urandom());
            wr(8'h89, c);
            @(posedge clk);
            ac = $urandom();
            wc = $urandom();
            fc = 48'({$urandom(), $urandom()});
            acmp <= ac;
            wcmp <= wc;
            fcmp <= fc;
            @(posedge clk);
            acmp <= '0;
            wcmp <= '0;
            fcmp <= '0;
            repeat (3) @(posedge clk);
            for (int i = 0; i < 2; i++)
            begin
                chk("alarm", c[3*i+2] ? 32'(ac[16*i+:16]) : 0,
                    32'(af[i]));
                chk("trip", c[3*i+1] ? 32'(fc[24*i+:24]) : 0,
                    32'(ff[i]));
                chk("warn", c[3*i] ? 32'(wc[16*i+:16]) : 0,
                    32'(wf[i]));
            end
            aclr <= '1;
            fclr <= '1;
            wclr <= '1;
            @(posedge clk);
            aclr <= '0;
            fclr <= '0;
            wclr <= '0;
            @(posedge clk);
            chk("flags cleared", 0, 32'(|{af, ff, wf}));
        end
        $display("test flags done");
        src <= 11'h000;
        wr(8'h8a, 8'h00);
        repeat (5) @(posedge clk);
        rd(8'hf0, 9'h100);
        wr(8'hf1, 8'h02);
        src <= 11'h004;
        repeat (6) @(posedge clk);
        chk("irq masked", 0, 32'(irq));
        wr(8'hf1, 8'h01);
        repeat (2) @(posedge clk);
        chk("irq", 1, 32'(irq));
        rd(8'hf0, 9'h001);
        repeat (2) @(posedge clk);
        chk("irq cleared", 0, 32'(irq));
        // denied accesses raise their own status bits
        pw <= 4'h0;
        wr(8'hf1, 8'h04);
        wr(8'h89, 8'hff);
        repeat (2) @(posedge clk);
        chk("irq denied", 1, 32'(irq));
        rd(8'h89, 9'h000);
        rd(8'hf0, 9'h00c);
        $display("test irq done");
        repeat (3) @(posedge clk);
        chk("pending reads", 0, 32'(expq.size()));
        end_sim();
    end
endmodule
`default_nettype wire
